// >>> audio_card_status_lamps.sv
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`include "lamp_consts.svh"

// Notes on behaviour
// - reset and controller test: health slow-flashes, activity and fault off.
// - unconfigured: health flashes, activity off, fault shows one-eighth flash pattern.
// - normal: health flashes, activity blinks on each received command.
// - normal and self test: fault lamp follows card fault; self test activity off.
// - cage test: fault lamp 1/8 duty, 7/8 when any slot faults.
// - cage test: health flashes, activity off, switch presses forwarded.
module audio_card_status_lamps #(
    parameter int EIGHTH_CYC = `EIGHTH_CYC,
    parameter int ACT_CYC    = `ACT_EIGHTHS * `EIGHTH_CYC
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // axi4-lite slave
    input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [`ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // backplane side
    input  wire logic                 cmd_rx,
    input  wire logic                 switch_pin,
    output logic                      switch_fwd,
    // lamps and interrupt
    output lamp_pkg::lamps_t          lamps,
    output logic                      irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    lamp_pkg::mode_t          mode_q, mode_d;
    logic [1:0]               fault_q, fault_d;
    logic [`INT_W-1:0]        stat_q, stat_d, mask_q, mask_d;
    logic                     bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]               bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]              rdata_q, rdata_d;
    logic [31:0]              presc_q, presc_d, act_q, act_d;
    logic [3:0]               ph_q, ph_d;
    logic                     sw_meta_q, sw_sync_q, sw_prev_q;
    logic                     fwd_q, fwd_d;
    lamp_pkg::lamps_t         lamps_q, lamps_d;
    logic                     wr_go, rd_go, tick, slow_on, norm_on, press;
    logic                     pat_lo, pat_hi;
    logic [`INT_W-1:0]        ev;

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    assign rd_go         = s_axi_arvalid & ~rvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // ----------------------------------------
    // flash timebase
    // ----------------------------------------
    assign tick    = (presc_q == 32'(EIGHTH_CYC - 1));
    assign norm_on = ph_q[2];
    assign slow_on = ph_q[3];
    assign pat_lo  = (ph_q[2:0] == 3'h7);
    assign pat_hi  = (ph_q[2:0] != 3'h0);
    assign press   = sw_sync_q & ~sw_prev_q;

    always_comb begin
        presc_d = tick ? 32'h0000_0000 : presc_q + 32'h0000_0001;
        ph_d    = tick ? ph_q + 4'h1 : ph_q;
    end

    // ----------------------------------------
    // register file and events
    // ----------------------------------------
    always_comb begin
        mode_d   = mode_q;
        fault_d  = fault_q;
        mask_d   = mask_q;
        bvalid_d = bvalid_q & ~s_axi_bready;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q & ~s_axi_rready;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        stat_d   = stat_q;
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d  = `RESP_OKAY;
            unique case (s_axi_awaddr)
                `REG_MODE: begin
                    if (s_axi_wstrb[0] && s_axi_wdata[2:0] <= 3'(lamp_pkg::M_CAGE_TEST))
                        mode_d = lamp_pkg::mode_t'(s_axi_wdata[2:0]);
                end
                `REG_FAULT: begin
                    if (s_axi_wstrb[0])
                        fault_d = s_axi_wdata[1:0];
                end
                `REG_LAMPS: begin
                end
                `REG_INT_STAT: begin
                    if (s_axi_wstrb[0])
                        stat_d = stat_q & ~s_axi_wdata[`INT_W-1:0];
                end
                `REG_INT_MASK: begin
                    if (s_axi_wstrb[0])
                        mask_d = s_axi_wdata[`INT_W-1:0];
                end
                default: bresp_d = `RESP_SLVERR;
            endcase
        end
        ev                 = '0;
        ev[`INT_CMD_BIT]   = cmd_rx;
        ev[`INT_SW_BIT]    = fwd_d;
        ev[`INT_FAULT_BIT] = lamps_d.fault & ~lamps_q.fault;
        stat_d             = stat_d | ev;
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d  = `RESP_OKAY;
            unique case (s_axi_araddr)
                `REG_MODE:     rdata_d = {29'h0, mode_q};
                `REG_FAULT:    rdata_d = {30'h0, fault_q};
                `REG_LAMPS:    rdata_d = {29'h0, lamps_q};
                `REG_INT_STAT: rdata_d = {29'h0, stat_q};
                `REG_INT_MASK: rdata_d = {29'h0, mask_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `RESP_SLVERR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // lamp encoding
    // ----------------------------------------
    always_comb begin
        act_d   = (act_q != 32'h0000_0000) ? act_q - 32'h0000_0001 : act_q;
        fwd_d   = 1'b0;
        lamps_d = '0;
        unique case (mode_q)
            lamp_pkg::M_RESET, lamp_pkg::M_CTRL_TEST: begin
                lamps_d.health = slow_on;
            end
            lamp_pkg::M_UNCONF: begin
                lamps_d.health = norm_on;
                lamps_d.fault  = pat_lo;
            end
            lamp_pkg::M_NORMAL: begin
                if (cmd_rx)
                    act_d = 32'(ACT_CYC);
                lamps_d.health   = norm_on;
                lamps_d.activity = (act_q != 32'h0000_0000);
                lamps_d.fault    = fault_q[`FAULT_CARD_BIT];
            end
            lamp_pkg::M_SELF_TEST: begin
                lamps_d.health = norm_on;
                lamps_d.fault  = fault_q[`FAULT_CARD_BIT];
            end
            lamp_pkg::M_CAGE_TEST: begin
                lamps_d.health = norm_on;
                fwd_d          = press;
                lamps_d.fault  = fault_q[`FAULT_SLOT_BIT] ? pat_hi : pat_lo;
            end
        endcase
        if (mode_q != lamp_pkg::M_NORMAL)
            act_d = 32'h0000_0000;
    end

    assign lamps      = lamps_q;
    assign switch_fwd = fwd_q;
    assign irq        = |(stat_q & mask_q);

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q    <= lamp_pkg::M_RESET;
            fault_q   <= 2'h0;
            stat_q    <= 3'h0;
            mask_q    <= 3'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0000_0000;
            presc_q   <= 32'h0000_0000;
            ph_q      <= 4'h0;
            act_q     <= 32'h0000_0000;
            sw_meta_q <= 1'b0;
            sw_sync_q <= 1'b0;
            sw_prev_q <= 1'b0;
            fwd_q     <= 1'b0;
            lamps_q   <= '0;
        end else begin
            mode_q    <= mode_d;
            fault_q   <= fault_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            presc_q   <= presc_d;
            ph_q      <= ph_d;
            act_q     <= act_d;
            sw_meta_q <= switch_pin;
            sw_sync_q <= sw_meta_q;
            sw_prev_q <= sw_sync_q;
            fwd_q     <= fwd_d;
            lamps_q   <= lamps_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_reset_lamps;
        (mode_q == lamp_pkg::M_RESET) |=> !lamps_q.activity && !lamps_q.fault && lamps_q.health == $past(slow_on);
    endproperty
    a_reset_lamps: assert property (p_reset_lamps) else $error("reset lamp pattern wrong");

    property p_unconf_lamps;
        (mode_q == lamp_pkg::M_UNCONF) |=> !lamps_q.activity && lamps_q.fault == $past(pat_lo) && lamps_q.health == $past(norm_on);
    endproperty
    a_unconf_lamps: assert property (p_unconf_lamps) else $error("unconfigured lamp pattern wrong");

    property p_cmd_blink;
        (mode_q == lamp_pkg::M_NORMAL && cmd_rx) ##1 (mode_q == lamp_pkg::M_NORMAL) |=> lamps_q.activity;
    endproperty
    a_cmd_blink: assert property (p_cmd_blink) else $error("activity lamp missed a command");

    property p_fault_follow;
        (mode_q == lamp_pkg::M_NORMAL || mode_q == lamp_pkg::M_SELF_TEST) |=> lamps_q.fault == $past(fault_q[0]);
    endproperty
    a_fault_follow: assert property (p_fault_follow) else $error("fault lamp not following fault");

    property p_cage_duty;
        (mode_q == lamp_pkg::M_CAGE_TEST) |=> lamps_q.fault == ($past(fault_q[1]) ? $past(ph_q[2:0]) != 3'h0 : $past(ph_q[2:0]) == 3'h7);
    endproperty
    a_cage_duty: assert property (p_cage_duty) else $error("cage test duty wrong");

    property p_switch_fwd;
        (mode_q == lamp_pkg::M_CAGE_TEST && press) |=> switch_fwd && !lamps_q.activity;
    endproperty
    a_switch_fwd: assert property (p_switch_fwd) else $error("switch press not forwarded");

    property p_rate;
        tick |=> ph_q == $past(ph_q) + 4'h1 && presc_q == 32'h0000_0000;
    endproperty
    a_rate: assert property (p_rate) else $error("flash phase did not advance");

    c_cage_fault: cover property (mode_q == lamp_pkg::M_CAGE_TEST && fault_q[1] && lamps_q.fault);
    c_cmd_normal: cover property (mode_q == lamp_pkg::M_NORMAL && cmd_rx);
    c_irq:        cover property (irq);

endmodule // audio_card_status_lamps

// >>> lamp_consts.svh
`ifndef LAMP_CONSTS_SVH
`define LAMP_CONSTS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_W          5
`define REG_MODE        5'h00
`define REG_FAULT       5'h04
`define REG_LAMPS       5'h08
`define REG_INT_STAT    5'h0C
`define REG_INT_MASK    5'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MODE_W          3
`define MODE_RST        3'h0
`define FAULT_CARD_BIT  0
`define FAULT_SLOT_BIT  1
`define INT_CMD_BIT     0
`define INT_SW_BIT      1
`define INT_FAULT_BIT   2
`define INT_W           3
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ         50
`define FLASH_PERIOD_MS 500
`define ACT_EIGHTHS     4
`define EIGHTH_CYC      ((`FLASH_PERIOD_MS * 1000 * `CLK_MHZ) / 8)

`endif

// >>> lamp_pkg.sv
package lamp_pkg;

    // card states shown on the lamps
    typedef enum logic [2:0] {
        M_RESET,
        M_UNCONF,
        M_NORMAL,
        M_SELF_TEST,
        M_CTRL_TEST,
        M_CAGE_TEST
    } mode_t;

    typedef struct packed {
        logic health;
        logic activity;
        logic fault;
    } lamps_t;

endpackage

// >>> cage_ctrl_model.sv
module cage_ctrl_model (
    // clock
    input  wire logic clock,
    // backplane lines
    output logic      cmd_rx,
    output logic      switch_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cmd_rx     = 1'b0;
        switch_pin = 1'b0;
    end

    // ----------------------------------------
    // one relayed command, one clock wide
    // ----------------------------------------
    task automatic send_cmd();
        @(posedge clock);
        cmd_rx <= 1'b1;
        @(posedge clock);
        cmd_rx <= 1'b0;
    endtask

    // ----------------------------------------
    // switch press held for some cycles
    // ----------------------------------------
    task automatic press(input int hold);
        @(posedge clock);
        switch_pin <= 1'b1;
        repeat (hold) @(posedge clock);
        switch_pin <= 1'b0;
    endtask
endmodule // cage_ctrl_model

// >>> tb.sv
`include "lamp_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic               clock;
    logic               rst;
    logic [`ADDR_W-1:0] aw_a;
    logic [`ADDR_W-1:0] ar_a;
    logic [31:0]        wd;
    logic [31:0]        rd;
    logic               awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [1:0]         bresp;
    logic [1:0]         rresp;
    logic               cmd_rx, switch_pin, switch_fwd, irq;
    lamp_pkg::lamps_t   lamps;
    int                 mismatches = 0;
    int                 comparisons = 0;
    int                 hon, htg, aon, fon, swc;
    logic [31:0]        seed = 32'h0000_8cae;

    audio_card_status_lamps #(.EIGHTH_CYC(4), .ACT_CYC(8)) audio_card_status_lamps_i (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .cmd_rx(cmd_rx), .switch_pin(switch_pin), .switch_fwd(switch_fwd),
        .lamps(lamps), .irq(irq));

    cage_ctrl_model cage_ctrl_model_i (.clock(clock), .cmd_rx(cmd_rx), .switch_pin(switch_pin));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ----------------------------------------
    // helpers and reference model
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int exp_fault(input int m, input logic [1:0] f);
        case (m)
            1:       return 8;
            2, 3:    return f[0] ? 64 : 0;
            5:       return f[1] ? 56 : 8;
            default: return 0;
        endcase
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic step(inout int n);
        @(negedge clock);
        n++;
        if (n > 200) begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        int   n      = 0;
        logic aw_hit = 1'b0;
        logic w_hit  = 1'b0;
        logic aw_t   = 1'b0;
        logic w_t    = 1'b0;
        @(posedge clock);
        aw_a <= a;
        wd   <= d;
        awv  <= 1'b1;
        wv   <= 1'b1;
        br   <= 1'b1;
        while (!(aw_t && w_t)) begin
            step(n);
            aw_hit = !aw_t && (awr === 1'b1);
            w_hit  = !w_t && (wr === 1'b1);
            @(posedge clock);
            if (aw_hit)
                awv <= 1'b0;
            if (w_hit)
                wv <= 1'b0;
            aw_t = aw_t | aw_hit;
            w_t  = w_t | w_hit;
        end
        do step(n); while (bv !== 1'b1);
        chk(32'(bresp), 32'(r));
        @(posedge clock);
        br <= 1'b0;
    endtask

    task automatic axr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        @(posedge clock);
        ar_a <= a;
        arv  <= 1'b1;
        rr   <= 1'b1;
        do step(n); while (arr !== 1'b1);
        @(posedge clock);
        arv <= 1'b0;
        do step(n); while (rv !== 1'b1);
        chk(rd, d);
        chk(32'(rresp), 32'(r));
        @(posedge clock);
        rr <= 1'b0;
    endtask

    task automatic measure();
        logic h;
        hon = 0;
        htg = 0;
        aon = 0;
        fon = 0;
        swc = 0;
        @(negedge clock);
        h = lamps.health;
        repeat (64) begin
            @(negedge clock);
            hon += int'(lamps.health === 1'b1);
            htg += int'(lamps.health !== h);
            aon += int'(lamps.activity === 1'b1);
            fon += int'(lamps.fault === 1'b1);
            swc += int'(switch_fwd === 1'b1);
            h = lamps.health;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst, awv, wv, br, arv, rr} = 6'h3f & 6'h20;
        {aw_a, ar_a, wd} = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        axr(`REG_MODE, 32'h0000_0000, `RESP_OKAY);
        axr(`REG_INT_MASK, 32'h0000_0000, `RESP_OKAY);
        axr(5'h14, 32'h0000_0000, `RESP_SLVERR);
        axw(5'h14, 32'h0000_0001, `RESP_SLVERR);
        for (int m = 0; m < 6; m++) begin
            for (int f = 0; f < 4; f++) begin
                axw(`REG_MODE, 32'(m), `RESP_OKAY);
                axw(`REG_FAULT, 32'(f), `RESP_OKAY);
                axr(`REG_FAULT, 32'(f), `RESP_OKAY);
                seed = lfsr(seed);
                repeat (8 + int'(seed[2:0])) @(posedge clock);
                measure();
                chk(32'(hon), 32'd32);
                chk(32'(htg), (m == 0 || m == 4) ? 32'd2 : 32'd4);
                chk(32'(aon), 32'd0);
                chk(32'(fon), 32'(exp_fault(m, 2'(f))));
            end
        end
        axw(`REG_MODE, 32'h0000_0003, `RESP_OKAY);
        seed = lfsr(seed);
        axw(`REG_MODE, 32'h0000_0006 | {31'h0000_0000, seed[0]}, `RESP_OKAY);
        axr(`REG_MODE, 32'h0000_0003, `RESP_OKAY);
        axw(`REG_MODE, 32'h0000_0002, `RESP_OKAY);
        axw(`REG_FAULT, 32'h0000_0000, `RESP_OKAY);
        axw(`REG_INT_STAT, 32'h0000_0007, `RESP_OKAY);
        axr(`REG_INT_STAT, 32'h0000_0000, `RESP_OKAY);
        fork
            measure();
            cage_ctrl_model_i.send_cmd();
        join
        chk(32'(aon), 32'd8);
        axr(`REG_INT_STAT, 32'h0000_0001, `RESP_OKAY);
        @(negedge clock);
        chk(32'(irq), 32'd0);
        axw(`REG_INT_MASK, 32'h0000_0001, `RESP_OKAY);
        @(negedge clock);
        chk(32'(irq), 32'd1);
        axw(`REG_INT_STAT, 32'h0000_0001, `RESP_OKAY);
        @(negedge clock);
        chk(32'(irq), 32'd0);
        fork
            measure();
            cage_ctrl_model_i.press(6);
        join
        chk(32'(swc), 32'd0);
        axr(`REG_INT_STAT, 32'h0000_0000, `RESP_OKAY);
        axw(`REG_MODE, 32'h0000_0005, `RESP_OKAY);
        fork
            measure();
            cage_ctrl_model_i.press(6);
        join
        chk(32'(swc), 32'd1);
        axr(`REG_INT_STAT, 32'h0000_0006, `RESP_OKAY);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        axr(`REG_MODE, 32'h0000_0000, `RESP_OKAY);
        axr(`REG_INT_STAT, 32'h0000_0000, `RESP_OKAY);
        wrap_up();
    end
endmodule // tb
